// file: src/gdc_pkg.sv
// Purpose: Shared constants and types for the gated decade count chain
// Assumes: One 50 MHz system clock drives both ends
// Notes: Register indices belong to the controller's software port
package gdc_pkg;
   // Clock and timing
   localparam int CLK_HZ = 50_000_000;
   localparam int RST_PULSE_NS = 1000;
   localparam int RST_CYC = (RST_PULSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int REF_DIV = 10_000;
   localparam int REF_HALF = REF_DIV / 2;
   localparam int TICK_HZ = 10;
   localparam int TICK_MS = 100;

   // Chain geometry
   localparam int N_DIG = 9;
   localparam int MUX_DIG = 8;
   localparam int SCAN_PULSES = 7;
   localparam int FIFO_DEPTH = 8;
   localparam int FIFO_W = 4;

   typedef logic [3:0] gdc_bcd_t;
   localparam gdc_bcd_t BCD_MAX = 4'h9;
   localparam gdc_bcd_t BCD_ZERO = 4'h0;

   // Software register indices
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_STAT = 4'h1;
   localparam logic [3:0] REG_DATA = 4'h2;
   localparam logic [3:0] REG_TICK = 4'h3;

   // Field positions
   localparam int CTRL_SEL_BIT = 0;
   localparam int CTRL_RST_BIT = 1;
   localparam int CTRL_READ_BIT = 2;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_AVAIL_BIT = 1;
   localparam int STAT_TICK_BIT = 2;
   localparam int STAT_FIRST_LSB = 4;

   // Reset values
   localparam logic SEL_RESET = 1'b0;
   localparam logic [31:0] TICK_RESET = 32'h0000_0000;

   typedef enum logic [5:0] {
      ST_IDLE = 6'b000001,
      ST_RST = 6'b000010,
      ST_LOAD = 6'b000100,
      ST_WAIT = 6'b001000,
      ST_PUSH = 6'b010000,
      ST_STEP = 6'b100000
   } gdc_state_e;
endpackage

// file: src/gdc_link_if.sv
// Purpose: Wires between the count chain and its controller
// Assumes: Both ends run on the same clk_sys
// Notes: Load and scan strobes are one clk_sys cycle long; count_rst is held for RST_CYC cycles
`timescale 1ns/10ps
`default_nettype none
interface gdc_link_if;
   logic in_sel;
   logic count_rst;
   logic latch_load;
   logic scan_clk;
   logic [3:0] mux_digit;
   logic [3:0] first_digit;
   logic tick_10hz;

   modport chain (
      input in_sel, count_rst, latch_load, scan_clk,
      output mux_digit, first_digit, tick_10hz
   );
   modport ctrl (
      output in_sel, count_rst, latch_load, scan_clk,
      input mux_digit, first_digit, tick_10hz
   );
endinterface
`default_nettype wire

// file: src/gdc_fifo.sv
// Purpose: Small synchronous FIFO for readout digits
// Assumes: Depth is a power of two
// Notes: Full and empty come from a pointer pair one bit wider than the index
`timescale 1ns/10ps
`default_nettype none
module gdc_fifo #(
   parameter int WIDTH = 4,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic ce,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW:0] wr_ptr_reg;
   logic [AW:0] rd_ptr_reg;
   logic push;
   logic pop;

   assign in_ready = (wr_ptr_reg ^ rd_ptr_reg) != {1'b1, {AW{1'b0}}};
   assign out_valid = wr_ptr_reg != rd_ptr_reg;
   assign out_data = mem_reg[rd_ptr_reg[AW-1:0]];
   assign push = ce && in_valid && in_ready;
   assign pop = ce && out_valid && out_ready;

   always_ff @(posedge clk_sys) begin
      if (push) begin
         mem_reg[wr_ptr_reg[AW-1:0]] <= in_data;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
      end else begin
         if (push) begin
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
         end
         if (pop) begin
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// file: src/gdc_chain.sv
// Purpose: Count chain end: input select, gated decades, readout, 10 Hz tick
// Assumes: Count and reference inputs are synchronous to clk_sys
// Notes: Edges are found by comparing with the previous sample
//
// Functional notes
// - Pass exactly one selected input to counting.
// - Count only while gate is active.
// - First decade value valid only after settling.
// - First decade carry always valid, clocks next.
// - Second decade clocks third, ripple cascade.
// - Six-decade stage clocked from third's BCD.
// - Controller reads eight digits by multiplexing.
// - Reset end points multiplexer at first digit.
// - Latch-load captures counts, current digit shown.
// - Seven scan pulses step remaining seven digits.
// - Least decade read directly, not multiplexed.
// - One reset line clears every stage.
// - Divide reference by ten thousand for 10 Hz.
// - Present tick for controller program timing.
`timescale 1ns/10ps
`default_nettype none
module gdc_chain (
   // Clock, reset, enable
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic ce,
   // Signal inputs
   input wire logic [1:0] if_in,
   input wire logic gate,
   input wire logic ref_in,
   // Status
   output logic decade_carry,
   // Controller link
   gdc_link_if.chain link
);
   import gdc_pkg::*;

   // Input select and edge detection
   logic sel_level;
   logic sel_prev_reg;
   logic cnt_pulse;

   // Decade stages
   gdc_bcd_t dig_reg [N_DIG];
   logic [N_DIG-1:0] inc;
   logic [N_DIG-1:0] carry;
   logic d2_msb_reg;

   // Readout
   gdc_bcd_t latch_reg [MUX_DIG];
   logic [2:0] idx_reg;
   logic rst_prev_reg;
   gdc_bcd_t mux_reg;
   gdc_bcd_t first_reg;
   logic carry_reg;

   // Reference divider
   logic ref_prev_reg;
   logic [13:0] ref_cnt_reg;
   logic tick_reg;

   assign sel_level = link.in_sel ? if_in[1] : if_in[0];

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         sel_prev_reg <= 1'b0;
      end else if (ce) begin
         sel_prev_reg <= sel_level;
      end
   end

   // Gate closes the path; a held count stays frozen
   assign cnt_pulse = ce && gate && sel_level && !sel_prev_reg;

   // Stage clocks: synchronous stand-ins for the ripple connections
   assign inc[0] = cnt_pulse;
   assign inc[1] = carry[0];
   assign inc[2] = carry[1];
   // Third stage wrap seen as its MSB falling, one cycle late
   assign inc[3] = ce && d2_msb_reg && !dig_reg[2][3];

   genvar g;
   generate
      for (g = 0; g < N_DIG; g++) begin : g_dec
         assign carry[g] = inc[g] && (dig_reg[g] == BCD_MAX);
         if (g > 3) begin : g_up
            assign inc[g] = carry[g-1];
         end

         always_ff @(posedge clk_sys or negedge rst_b) begin
            if (!rst_b) begin
               dig_reg[g] <= BCD_ZERO;
            end else if (ce) begin
               if (link.count_rst) begin
                  dig_reg[g] <= BCD_ZERO;
               end else if (inc[g]) begin
                  dig_reg[g] <= carry[g] ? BCD_ZERO : dig_reg[g] + 4'h1;
               end
            end
         end
      end
   endgenerate

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         d2_msb_reg <= 1'b0;
      end else if (ce) begin
         if (link.count_rst) begin
            d2_msb_reg <= 1'b0;
         end else begin
            d2_msb_reg <= dig_reg[2][3];
         end
      end
   end

   // Carry is usable at any time, even mid count
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         carry_reg <= 1'b0;
      end else if (ce) begin
         carry_reg <= carry[0];
      end
   end

   assign decade_carry = carry_reg;

   // First decade only follows while the gate is shut, so it never
   // shows a value that is still moving
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         first_reg <= BCD_ZERO;
      end else if (ce && !gate) begin
         first_reg <= dig_reg[0];
      end
   end

   assign link.first_digit = first_reg;

   // Multiplex latches: stages two to nine
   generate
      for (g = 0; g < MUX_DIG; g++) begin : g_lat
         always_ff @(posedge clk_sys or negedge rst_b) begin
            if (!rst_b) begin
               latch_reg[g] <= BCD_ZERO;
            end else if (ce && link.latch_load) begin
               latch_reg[g] <= dig_reg[g+1];
            end
         end
      end
   endgenerate

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         rst_prev_reg <= 1'b0;
      end else if (ce) begin
         rst_prev_reg <= link.count_rst;
      end
   end

   // Digit pointer; wraps after the eighth digit
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         idx_reg <= 3'h0;
      end else if (ce) begin
         if (rst_prev_reg && !link.count_rst) begin
            idx_reg <= 3'h0;
         end else if (link.scan_clk) begin
            idx_reg <= idx_reg + 3'h1;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         mux_reg <= BCD_ZERO;
      end else if (ce) begin
         mux_reg <= latch_reg[idx_reg];
      end
   end

   assign link.mux_digit = mux_reg;

   // Reference divider: half period of the tick per count run
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         ref_prev_reg <= 1'b0;
      end else if (ce) begin
         ref_prev_reg <= ref_in;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         ref_cnt_reg <= 14'h0000;
         tick_reg <= 1'b0;
      end else if (ce && ref_in && !ref_prev_reg) begin
         if (ref_cnt_reg == 14'(REF_HALF - 1)) begin
            ref_cnt_reg <= 14'h0000;
            tick_reg <= !tick_reg;
         end else begin
            ref_cnt_reg <= ref_cnt_reg + 14'h0001;
         end
      end
   end

   assign link.tick_10hz = tick_reg;
endmodule
`default_nettype wire

// file: src/gdc_ctrl.sv
// Purpose: Controller end: reset, latch and scan sequence, digit FIFO
// Assumes: Software port strobes are one cycle long
// Notes: Readout stalls while the FIFO is full
`timescale 1ns/10ps
`default_nettype none
module gdc_ctrl (
   // Clock, reset, enable
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic ce,
   // Software port
   input wire logic [3:0] addr,
   input wire logic [31:0] wr_data,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic [31:0] rd_data,
   // Chain link
   gdc_link_if.ctrl link
);
   import gdc_pkg::*;

   gdc_state_e state_reg;
   logic sel_reg;
   logic [5:0] cyc_reg;
   logic [2:0] dcnt_reg;
   logic tick_prev_reg;
   logic [31:0] tick_cnt_reg;
   logic [31:0] rd_reg;
   logic fifo_ready;
   logic fifo_valid;
   gdc_bcd_t fifo_head;
   logic pop;
   logic push;

   assign link.in_sel = sel_reg;
   assign link.count_rst = state_reg == ST_RST;
   assign link.latch_load = state_reg == ST_LOAD;
   assign link.scan_clk = state_reg == ST_STEP;
   assign push = state_reg == ST_PUSH;
   assign pop = rd_en && addr == REG_DATA;

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         sel_reg <= SEL_RESET;
      end else if (ce && wr_en && addr == REG_CTRL) begin
         sel_reg <= wr_data[CTRL_SEL_BIT];
      end
   end

   // Commands are ignored while a sequence runs
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         state_reg <= ST_IDLE;
         cyc_reg <= 6'h00;
         dcnt_reg <= 3'h0;
      end else if (ce) begin
         unique case (state_reg)
            ST_IDLE: begin
               if (wr_en && addr == REG_CTRL && wr_data[CTRL_RST_BIT]) begin
                  state_reg <= ST_RST;
                  cyc_reg <= 6'h00;
               end else if (wr_en && addr == REG_CTRL && wr_data[CTRL_READ_BIT]) begin
                  state_reg <= ST_LOAD;
                  dcnt_reg <= 3'h0;
               end
            end
            ST_RST: begin
               if (cyc_reg == 6'(RST_CYC - 1)) begin
                  state_reg <= ST_IDLE;
               end else begin
                  cyc_reg <= cyc_reg + 6'h01;
               end
            end
            ST_LOAD: state_reg <= ST_WAIT;
            ST_WAIT: state_reg <= ST_PUSH;
            ST_PUSH: begin
               if (fifo_ready) begin
                  if (dcnt_reg == 3'(SCAN_PULSES)) begin
                     state_reg <= ST_IDLE;
                  end else begin
                     state_reg <= ST_STEP;
                     dcnt_reg <= dcnt_reg + 3'h1;
                  end
               end
            end
            ST_STEP: state_reg <= ST_WAIT;
         endcase
      end
   end

   gdc_fifo #(
      .WIDTH(FIFO_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .ce(ce),
      .in_valid(push),
      .in_ready(fifo_ready),
      .in_data(link.mux_digit),
      .out_valid(fifo_valid),
      .out_ready(pop),
      .out_data(fifo_head)
   );

   // Tick edges counted for program timing
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         tick_prev_reg <= 1'b0;
         tick_cnt_reg <= TICK_RESET;
      end else if (ce) begin
         tick_prev_reg <= link.tick_10hz;
         if (wr_en && addr == REG_TICK) begin
            tick_cnt_reg <= TICK_RESET;
         end else if (link.tick_10hz && !tick_prev_reg) begin
            tick_cnt_reg <= tick_cnt_reg + 32'h0000_0001;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         rd_reg <= 32'h0000_0000;
      end else if (ce) begin
         rd_reg <= 32'h0000_0000;
         if (rd_en) begin
            unique case (addr)
               REG_CTRL: rd_reg[CTRL_SEL_BIT] <= sel_reg;
               REG_STAT: begin
                  rd_reg[STAT_BUSY_BIT] <= state_reg != ST_IDLE;
                  rd_reg[STAT_AVAIL_BIT] <= fifo_valid;
                  rd_reg[STAT_TICK_BIT] <= link.tick_10hz;
                  rd_reg[STAT_FIRST_LSB +: 4] <= link.first_digit;
               end
               REG_DATA: rd_reg[3:0] <= fifo_valid ? fifo_head : BCD_ZERO;
               REG_TICK: rd_reg <= tick_cnt_reg;
               default: rd_reg <= 32'h0000_0000;
            endcase
         end
      end
   end

   assign rd_data = rd_reg;
endmodule
`default_nettype wire

// file: test/gdc_link_sva.sv
// Purpose: Link protocol checks between chain and controller
// Assumes: Single clk_sys domain
// Notes: Sees the link only; digit values are judged by the bench
`timescale 1ns/10ps
`default_nettype none
module gdc_link_sva
   import gdc_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // Link
   input wire logic in_sel,
   input wire logic count_rst,
   input wire logic latch_load,
   input wire logic scan_clk,
   input wire logic [3:0] mux_digit,
   input wire logic [3:0] first_digit,
   input wire logic tick_10hz
);
   int rst_len;
   int scans;
   default clocking @(posedge clk_sys);
   endclocking
   default disable iff (!rst_b);
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b)
         rst_len <= 0;
      else
         rst_len <= count_rst ? rst_len + 1 : 0;
   end
   // Scans since the last latch load
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b)
         scans <= 0;
      else if (latch_load)
         scans <= 0;
      else
         scans <= scans + int'(scan_clk);
   end
   property p_rst_len;
      $fell(count_rst) |-> rst_len == RST_CYC;
   endproperty
   a_rst_len: assert property (p_rst_len) else $error("stage reset length wrong");
   property p_load_pulse;
      latch_load |=> !latch_load;
   endproperty
   a_load_pulse: assert property (p_load_pulse) else $error("latch load too long");
   property p_load_alone;
      latch_load |-> !scan_clk && !count_rst;
   endproperty
   a_load_alone: assert property (p_load_alone) else $error("latch load overlaps");
   property p_scan_gap;
      scan_clk |=> !scan_clk [*2];
   endproperty
   a_scan_gap: assert property (p_scan_gap) else $error("scan pulses too close");
   property p_scan_lim;
      scan_clk |-> scans < SCAN_PULSES;
   endproperty
   a_scan_lim: assert property (p_scan_lim) else $error("too many scan pulses");
   property p_load_cnt;
      latch_load |-> scans == 0 || scans == SCAN_PULSES;
   endproperty
   a_load_cnt: assert property (p_load_cnt) else $error("readout cut short");
   property p_bcd;
      mux_digit <= BCD_MAX && first_digit <= BCD_MAX;
   endproperty
   a_bcd: assert property (p_bcd) else $error("digit not BCD");
   property p_mux_cause;
      $changed(mux_digit) |-> $past(latch_load, 2) || $past(scan_clk, 2) ||
         $past(count_rst, 2) || $past(count_rst, 3) || $past(count_rst, 4);
   endproperty
   a_mux_cause: assert property (p_mux_cause) else $error("digit moved uncaused");
   property p_tick;
      $changed(tick_10hz) |=> $stable(tick_10hz) [*8];
   endproperty
   a_tick: assert property (p_tick) else $error("tick toggles too fast");
   property p_sel;
      count_rst && $past(count_rst) |-> $stable(in_sel);
   endproperty
   a_sel: assert property (p_sel) else $error("select moved in reset");
   c_load: cover property (latch_load);
   c_scan: cover property (scan_clk && scans == 6);
   c_tick: cover property ($rose(tick_10hz));
endmodule
`default_nettype wire

// file: test/tb.sv
// Purpose: Self-checking bench for chain and controller on one link
// Assumes: Reference edges come every two clocks to keep the run short
// Notes: Counts stay under five digits, so high decades read zero
`timescale 1ns/10ps
`default_nettype none
module tb;
   import gdc_pkg::*;
   logic clk_sys, rst_b, ce, gate, ref_in, wr_en, rd_en, rd_d, chk, chk_d, decade_carry;
   logic [1:0] if_in;
   logic [3:0] addr;
   logic [31:0] wr_data, rd_data, rd_val, rng;
   logic [31:0] exp_q[$];
   int n_errors, samples_checked, n_carry, fd;
   gdc_link_if link();
   gdc_chain i_gdc_chain(.clk_sys(clk_sys), .rst_b(rst_b), .ce(ce), .if_in(if_in),
      .gate(gate), .ref_in(ref_in), .decade_carry(decade_carry), .link(link));
   gdc_ctrl i_gdc_ctrl(.clk_sys(clk_sys), .rst_b(rst_b), .ce(ce), .addr(addr),
      .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .link(link));
   gdc_link_sva i_gdc_link_sva(.clk_sys(clk_sys), .rst_b(rst_b), .in_sel(link.in_sel),
      .count_rst(link.count_rst), .latch_load(link.latch_load), .scan_clk(link.scan_clk),
      .mux_digit(link.mux_digit), .first_digit(link.first_digit), .tick_10hz(link.tick_10hz));
   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   function automatic int dig(input int n, input int d);
      repeat (d) n = n / 10;
      return n % 10;
   endfunction
   task automatic cmp(input logic [31:0] got, input logic [31:0] want);
      samples_checked++;
      if (got !== want) begin
         n_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, want);
      end
   endtask
   // Read data stand only in the cycle after the strobe
   always @(posedge clk_sys) begin
      if (rd_d === 1'b1) begin
         rd_val <= rd_data;
         if (chk_d === 1'b1)
            cmp(rd_data, exp_q.pop_front());
      end
      rd_d <= rd_en;
      chk_d <= chk;
      if (decade_carry === 1'b1)
         n_carry++;
   end
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      addr <= a;
      wr_data <= d;
      wr_en <= 1'b1;
      @(posedge clk_sys);
      wr_en <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic c, input logic [31:0] e);
      @(posedge clk_sys);
      if (c)
         exp_q.push_back(e);
      addr <= a;
      rd_en <= 1'b1;
      chk <= c;
      @(posedge clk_sys);
      rd_en <= 1'b0;
      @(posedge clk_sys);
      #1;
   endtask
   task automatic wait_idle;
      for (int k = 0; k < 200; k++) begin
         rd(REG_STAT, 1'b0, 32'h0);
         if (rd_val[STAT_BUSY_BIT] === 1'b0)
            break;
      end
      cmp(32'(rd_val[STAT_BUSY_BIT]), 32'h0);
   endtask
   // Sel 2 pulses the reference; the idle count input gets noise
   task automatic pulses(input int sel, input int n);
      logic [1:0] v;
      repeat (n) begin
         for (int h = 0; h < 2; h++) begin
            rng = xs(rng);
            v = rng[1:0];
            if (sel < 2)
               v[sel] = (h == 0);
            @(posedge clk_sys);
            if_in <= v;
            ref_in <= (sel == 2) && (h == 0);
         end
      end
   endtask
   task automatic run(input int sel);
      int n, c0;
      rng = xs(rng);
      n = 995 + int'(rng % 9000);
      wr(REG_CTRL, 32'h2 | sel);
      wait_idle();
      rd(REG_STAT, 1'b1, 32'h0);
      rd(REG_CTRL, 1'b1, sel);
      c0 = n_carry;
      @(posedge clk_sys);
      gate <= 1'b1;
      if_in <= 2'b00;
      pulses(sel, n);
      // Clock enable low must freeze the count
      repeat (2) @(posedge clk_sys);
      ce <= 1'b0;
      pulses(sel, 4);
      ce <= 1'b1;
      repeat (2) @(posedge clk_sys);
      gate <= 1'b0;
      pulses(sel, 5);
      repeat (4) @(posedge clk_sys);
      cmp(n_carry - c0, n / 10);
      fd = n % 10;
      rd(REG_STAT, 1'b1, fd << STAT_FIRST_LSB);
      wr(REG_CTRL, 32'h4 | sel);
      wait_idle();
      rd(REG_STAT, 1'b1, (fd << STAT_FIRST_LSB) | 2);
      wr(REG_CTRL, 32'h4 | sel);
      // Second readout starts on a full FIFO and wraps the index
      for (int k = 0; k < 16; k++) begin
         if (k == 8)
            wait_idle();
         rd(REG_DATA, 1'b1, dig(n, k < 8 ? k + 1 : (k == 8 ? 8 : k - 8)));
      end
      rd(REG_DATA, 1'b1, 32'h0);
      $display("Test count on input %0d done", sel);
   endtask
   task automatic stop_test;
      $display("Checks %0d, errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      // Longest legal run is about 72k cycles
      #1_700_000;
      n_errors++;
      $display("Error at %0t: watchdog expired", $time);
      stop_test();
   end
   initial begin
      rng = 32'he6f8;
      {rst_b, gate, ref_in, wr_en, rd_en, chk} = '0;
      ce = 1'b1;
      if_in = 2'b00;
      addr = 4'h0;
      wr_data = 32'h0;
      {n_errors, samples_checked, n_carry, fd} = '0;
      repeat (2) @(posedge clk_sys);
      rst_b <= 1'b1;
      rd(REG_STAT, 1'b1, 32'h0);
      rd(4'h7, 1'b1, 32'h0);
      wr(4'h7, 32'hffff_ffff);
      rd(REG_CTRL, 1'b1, 32'h0);
      $display("Test reset and map done");
      run(0);
      run(1);
      wr(REG_TICK, 32'h0);
      pulses(2, REF_HALF - 1);
      repeat (4) @(posedge clk_sys);
      rd(REG_TICK, 1'b1, 32'h0);
      pulses(2, 1);
      repeat (4) @(posedge clk_sys);
      rd(REG_TICK, 1'b1, 32'h1);
      rd(REG_STAT, 1'b1, (fd << STAT_FIRST_LSB) | 4);
      pulses(2, REF_DIV);
      repeat (4) @(posedge clk_sys);
      rd(REG_TICK, 1'b1, 32'h2);
      wr(REG_TICK, 32'h1);
      rd(REG_TICK, 1'b1, 32'h0);
      $display("Test tick done");
      // Reset again mid run, then a combined command, and a read command while busy
      @(posedge clk_sys);
      rst_b <= 1'b0;
      repeat (2) @(posedge clk_sys);
      rst_b <= 1'b1;
      rd(REG_TICK, 1'b1, 32'h0);
      rd(REG_CTRL, 1'b1, 32'h0);
      wr(REG_CTRL, 32'h6);
      wr(REG_CTRL, 32'h4);
      wait_idle();
      rd(REG_STAT, 1'b1, 32'h0);
      $display("Test second reset done");
      stop_test();
   end
endmodule
`default_nettype wire
